// ### hw/resp_fifo.sv
// response byte fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module resp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_in) begin
    if (in_valid_in && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
    end else if (in_valid_in && !full) begin
      wr_ptr <= wr_ptr + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_ptr <= '0;
    end else if (out_ready_in && !empty) begin
      rd_ptr <= rd_ptr + (AW+1)'(1);
    end
  end
endmodule
`default_nettype wire

// ### hw/spi_flash_command_engine.sv
// buffered command engine driving an external serial flash
`timescale 1ns/1ps
`default_nettype none
`include "spi_flash_params.svh"
module spi_flash_command_engine (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // canned command loader
  input wire logic load_in,
  input wire spi_flash_pkg::op_e load_op_in,
  input wire logic [23:0] load_addr_in,
  input wire logic [7:0] load_data_in,
  // raw command buffer and length
  input wire logic cmd_wr_in,
  input wire logic [2:0] cmd_index_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic length_wr_in,
  input wire logic [7:0] length_in,
  // control and status
  input wire logic start_in,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] length_out,
  // response buffer read port
  input wire logic [2:0] rsp_index_in,
  output logic [7:0] rsp_byte_out,
  // response byte stream
  output logic rsp_valid_out,
  input wire logic rsp_ready_in,
  output logic [7:0] rsp_data_out,
  // flash pins
  output logic flash_cs_n_out,
  output logic flash_sck_out,
  output logic flash_mosi_out,
  input wire logic flash_serial_in
);
  import spi_flash_pkg::*;

  localparam logic [3:0] HALF_LAST = 4'(`SCK_HALF_CYC - 1);

  state_e state;
  op_e cur_op;
  logic [7:0] command_buffer [`BUF_DEPTH];
  logic [7:0] response_buffer [`BUF_DEPTH];
  logic [7:0] command_length;
  logic [3:0] half_cnt;
  logic tick;
  logic [2:0] bit_cnt;
  logic [7:0] byte_idx;
  logic [7:0] next_idx;
  logic [7:0] tx_shift;
  logic [7:0] rx_shift;
  logic rx_meta;
  logic rx_sync;
  logic capture_ok;
  logic byte_end;
  logic push;
  logic fifo_ready;
  logic go;
  logic idle;

  assign idle = (state == st_idle);
  assign go = start_in && idle && (command_length != `LEN_RESET);
  assign tick = !idle && (half_cnt == HALF_LAST);
  assign next_idx = byte_idx + 8'h01;
  // erase, program and single commands return nothing useful
  assign capture_ok = (cur_op == op_raw) || (cur_op == op_read_id);
  assign byte_end = (state == st_high) && tick && (bit_cnt == 3'd0);
  assign push = byte_end && capture_ok && (byte_idx != 8'h00);
  assign busy_out = !idle;
  assign flash_mosi_out = tx_shift[7];
  assign length_out = command_length;

  // input synchroniser
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
    end else begin
      rx_meta <= flash_serial_in;
      rx_sync <= rx_meta;
    end
  end

  // command buffer fill: canned loads or raw bytes, locked while busy
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < `BUF_DEPTH; i++) begin
        command_buffer[i] <= 8'h00;
      end
      command_length <= `LEN_RESET;
      cur_op <= op_raw;
    end else if (idle && load_in) begin
      cur_op <= load_op_in;
      command_buffer[1] <= load_addr_in[23:16];
      command_buffer[2] <= load_addr_in[15:8];
      command_buffer[3] <= load_addr_in[7:0];
      unique case (load_op_in)
        op_sector_erase: begin
          command_buffer[0] <= `OPC_SECTOR_ERASE;
          command_length <= `LEN_ERASE;
        end
        op_block32k_erase: begin
          command_buffer[0] <= `OPC_BLOCK32K_ERASE;
          command_length <= `LEN_ERASE;
        end
        op_block64k_erase: begin
          command_buffer[0] <= `OPC_BLOCK64K_ERASE;
          command_length <= `LEN_ERASE;
        end
        op_byte_program: begin
          command_buffer[0] <= `OPC_BYTE_PROGRAM;
          command_buffer[4] <= load_data_in;
          command_length <= `LEN_PROGRAM;
        end
        op_single: begin
          command_buffer[0] <= load_data_in;
          command_length <= `LEN_SINGLE;
        end
        op_read_id: begin
          command_buffer[0] <= `OPC_READ_ID;
          command_length <= `LEN_READ_ID;
        end
        default: begin
          command_buffer[0] <= load_data_in;
        end
      endcase
    end else if (idle) begin
      if (cmd_wr_in) begin
        command_buffer[cmd_index_in] <= cmd_byte_in;
        cur_op <= op_raw;
      end
      if (length_wr_in) begin
        command_length <= length_in;
        cur_op <= op_raw;
      end
    end
  end

  // half-period divider for the serial clock
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      half_cnt <= 4'h0;
    end else if (idle || tick) begin
      half_cnt <= 4'h0;
    end else begin
      half_cnt <= half_cnt + 4'h1;
    end
  end

  // transfer sequencer
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= st_idle;
      flash_cs_n_out <= 1'b1;
      flash_sck_out <= 1'b0;
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
      bit_cnt <= 3'd0;
      byte_idx <= 8'h00;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (state)
        st_idle: begin
          if (go) begin
            flash_cs_n_out <= 1'b0;
            tx_shift <= command_buffer[0];
            bit_cnt <= 3'd7;
            byte_idx <= 8'h00;
            state <= st_lead;
          end
        end
        st_lead, st_low: begin
          if (tick) begin
            flash_sck_out <= 1'b1;
            rx_shift <= {rx_shift[6:0], rx_sync};
            state <= st_high;
          end
        end
        st_high: begin
          if (tick && bit_cnt != 3'd0) begin
            flash_sck_out <= 1'b0;
            tx_shift <= {tx_shift[6:0], 1'b0};
            bit_cnt <= bit_cnt - 3'd1;
            state <= st_low;
          end else if (byte_end && (!push || fifo_ready)) begin
            flash_sck_out <= 1'b0;
            if (next_idx == command_length) begin
              state <= st_trail;
            end else begin
              byte_idx <= next_idx;
              bit_cnt <= 3'd7;
              if (next_idx < 8'(`BUF_DEPTH)) begin
                tx_shift <= command_buffer[next_idx[2:0]];
              end else begin
                tx_shift <= `DONT_CARE_BYTE;
              end
              state <= st_low;
            end
          end
        end
        st_trail: begin
          if (tick) begin
            flash_cs_n_out <= 1'b1;
            done_out <= 1'b1;
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // response buffer capture, bytes after the opcode
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < `BUF_DEPTH; i++) begin
        response_buffer[i] <= 8'h00;
      end
      rsp_byte_out <= 8'h00;
    end else begin
      if (push && fifo_ready && byte_idx <= 8'(`BUF_DEPTH)) begin
        response_buffer[3'(byte_idx - 8'h01)] <= rx_shift;
      end
      rsp_byte_out <= response_buffer[rsp_index_in];
    end
  end

  resp_fifo #(
    .WIDTH(8),
    .DEPTH(`RSP_FIFO_DEPTH)
  ) u_resp_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .in_data_in(rx_shift),
    .out_valid_out(rsp_valid_out),
    .out_ready_in(rsp_ready_in),
    .out_data_out(rsp_data_out)
  );

  // helper counters for the checks
  logic [15:0] rise_cnt;
  logic [7:0] cap_cnt;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rise_cnt <= 16'h0000;
      cap_cnt <= 8'h00;
    end else if (go) begin
      rise_cnt <= 16'h0000;
      cap_cnt <= 8'h00;
    end else begin
      if ((state == st_lead || state == st_low) && tick) begin
        rise_cnt <= rise_cnt + 16'h0001;
      end
      if (push && fifo_ready) begin
        cap_cnt <= cap_cnt + 8'h01;
      end
    end
  end

  sequence s_go;
    start_in && idle && command_length != `LEN_RESET;
  endsequence
  sequence s_select_held;
    !flash_cs_n_out [*2];
  endsequence
  property p_start_selects;
    @(posedge clk_in) disable iff (!nrst_in) s_go |=> s_select_held;
  endproperty
  a_start_selects: assert property (p_start_selects) else $error("start did not select");
  property p_clock_count;
    @(posedge clk_in) disable iff (!nrst_in)
      $rose(flash_cs_n_out) |-> rise_cnt == {5'h00, command_length, 3'b000};
  endproperty
  a_clock_count: assert property (p_clock_count) else $error("wrong clock count");
  property p_erase_load;
    @(posedge clk_in) disable iff (!nrst_in)
      idle && load_in && load_op_in == op_sector_erase |=>
        command_buffer[0] == `OPC_SECTOR_ERASE && command_length == `LEN_ERASE;
  endproperty
  a_erase_load: assert property (p_erase_load) else $error("bad erase load");
  property p_block_erase_load;
    @(posedge clk_in) disable iff (!nrst_in)
      idle && load_in && load_op_in == op_block64k_erase |=>
        command_buffer[0] == `OPC_BLOCK64K_ERASE && command_length == `LEN_ERASE;
  endproperty
  a_block_erase_load: assert property (p_block_erase_load) else $error("bad erase");
  property p_program_load;
    @(posedge clk_in) disable iff (!nrst_in)
      idle && load_in && load_op_in == op_byte_program |=>
        command_buffer[0] == `OPC_BYTE_PROGRAM && command_length == `LEN_PROGRAM
        && command_buffer[4] == $past(load_data_in);
  endproperty
  a_program_load: assert property (p_program_load) else $error("bad program load");
  property p_single_load;
    @(posedge clk_in) disable iff (!nrst_in)
      idle && load_in && load_op_in == op_single |=> command_length == `LEN_SINGLE;
  endproperty
  a_single_load: assert property (p_single_load) else $error("bad single load");
  property p_id_load;
    @(posedge clk_in) disable iff (!nrst_in)
      idle && load_in && load_op_in == op_read_id |=>
        command_buffer[0] == `OPC_READ_ID && command_length == `LEN_READ_ID;
  endproperty
  a_id_load: assert property (p_id_load) else $error("bad id load");
  property p_no_erase_capture;
    @(posedge clk_in) disable iff (!nrst_in)
      $rose(flash_cs_n_out) && cur_op != op_raw && cur_op != op_read_id |-> cap_cnt == 8'h00;
  endproperty
  a_no_erase_capture: assert property (p_no_erase_capture) else $error("capture in erase");
  property p_id_three_bytes;
    @(posedge clk_in) disable iff (!nrst_in)
      $rose(flash_cs_n_out) && cur_op == op_read_id |-> cap_cnt == 8'h03;
  endproperty
  a_id_three_bytes: assert property (p_id_three_bytes) else $error("id bytes missing");
  property p_sck_idle_low;
    @(posedge clk_in) disable iff (!nrst_in) flash_cs_n_out |-> !flash_sck_out;
  endproperty
  a_sck_idle_low: assert property (p_sck_idle_low) else $error("clock not idle low");
  property p_mosi_stable_high;
    @(posedge clk_in) disable iff (!nrst_in)
      flash_sck_out && $past(flash_sck_out) |-> $stable(flash_mosi_out);
  endproperty
  a_mosi_stable_high: assert property (p_mosi_stable_high) else $error("data moved");
  property p_surplus_dont_care;
    @(posedge clk_in) disable iff (!nrst_in)
      state == st_low && byte_idx >= 8'(`BUF_DEPTH) && bit_cnt == 3'd7 |-> flash_mosi_out;
  endproperty
  a_surplus_dont_care: assert property (p_surplus_dont_care) else $error("bad filler");
endmodule
`default_nettype wire

// ### hw/spi_flash_params.svh
// constants for the serial flash command engine
`ifndef SPI_FLASH_PARAMS_SVH
`define SPI_FLASH_PARAMS_SVH

`define OPC_SECTOR_ERASE 8'h20
`define OPC_BLOCK32K_ERASE 8'h52
`define OPC_BLOCK64K_ERASE 8'hd8
`define OPC_BYTE_PROGRAM 8'h02
`define OPC_READ_ID 8'h9f

`define LEN_ERASE 8'h04
`define LEN_PROGRAM 8'h05
`define LEN_SINGLE 8'h01
`define LEN_READ_ID 8'h04
`define LEN_RESET 8'h00

`define BUF_DEPTH 8
`define RSP_FIFO_DEPTH 8
`define DONT_CARE_BYTE 8'hff

`define CLK_PERIOD_NS 40
`define SCK_HALF_NS 160
`define SCK_HALF_CYC ((`SCK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### hw/spi_flash_pkg.sv
// types for the serial flash command engine
package spi_flash_pkg;
  typedef enum logic [2:0] {
    op_raw,
    op_sector_erase,
    op_block32k_erase,
    op_block64k_erase,
    op_byte_program,
    op_single,
    op_read_id
  } op_e;

  typedef enum logic [2:0] {
    st_idle,
    st_lead,
    st_high,
    st_low,
    st_trail
  } state_e;
endpackage

// ### tb/flash_model.sv
// serial flash stand-in: records command bytes, returns reply bytes
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  // flash pins
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic mosi_in,
  output logic miso_out,
  // reply stream, first byte after the opcode in the top bits
  input wire logic [63:0] reply_in
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  int n_rise;
  initial begin
    miso_out = 1'b0;
    sh = 8'h00;
    n_rise = 0;
  end
  always @(negedge cs_n_in) begin
    n_rise = 0;
    rx_q.delete();
  end
  // command bits taken on rising edge, msb first
  always @(posedge sck_in) begin
    if (!cs_n_in) begin
      sh = {sh[6:0], mosi_in};
      n_rise++;
      if (n_rise % 8 == 0)
        rx_q.push_back(sh);
    end
  end
  // reply bits after the opcode byte, changed on falling edge
  always @(negedge sck_in) begin
    if (!cs_n_in && n_rise >= 8)
      miso_out = reply_in[63 - ((n_rise - 8) % 64)];
  end
  // released line shows the inverse of the last bit
  always @(posedge cs_n_in) miso_out = ~miso_out;
endmodule
`default_nettype wire

// ### tb/spi_flash_command_engine_tb_top.sv
// self-checking bench for the serial flash command engine
`timescale 1ns/1ps
`default_nettype none
module spi_flash_command_engine_tb_top;
  import spi_flash_pkg::*;
  localparam logic [23:0] ID_CODE = 24'h5a3c96; // arbitrary value
  logic clk, nrst, load, cmd_wr, length_wr, start, busy, done, rsp_valid, rsp_ready;
  logic cs_n, sck, mosi, miso;
  op_e op;
  logic [23:0] addr;
  logic [7:0] data, cmd_byte, length, length_o, rsp_byte, rsp_data;
  logic [2:0] cmd_index, rsp_index;
  logic [63:0] reply;
  logic [31:0] seed = 32'h4c7f;
  logic [7:0] mbuf[8];
  logic [7:0] got_q[$];
  int mlen, mcap, n_fail, n_checks;
  op_e eops[3] = '{op_sector_erase, op_block32k_erase, op_block64k_erase};

  spi_flash_command_engine spi_flash_command_engine_inst (
    .clk_in(clk), .nrst_in(nrst), .load_in(load), .load_op_in(op),
    .load_addr_in(addr), .load_data_in(data), .cmd_wr_in(cmd_wr),
    .cmd_index_in(cmd_index), .cmd_byte_in(cmd_byte), .length_wr_in(length_wr),
    .length_in(length), .start_in(start), .busy_out(busy), .done_out(done),
    .length_out(length_o), .rsp_index_in(rsp_index), .rsp_byte_out(rsp_byte),
    .rsp_valid_out(rsp_valid), .rsp_ready_in(rsp_ready), .rsp_data_out(rsp_data),
    .flash_cs_n_out(cs_n), .flash_sck_out(sck), .flash_mosi_out(mosi),
    .flash_serial_in(miso)
  );
  flash_model flash_model_inst (
    .cs_n_in(cs_n), .sck_in(sck), .mosi_in(mosi), .miso_out(miso), .reply_in(reply)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic tick();
    @(negedge clk);
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic load_cmd(input op_e o, input logic [23:0] a, input logic [7:0] d);
    op = o;
    addr = a;
    data = d;
    load = 1'b1;
    tick();
    load = 1'b0;
    {mbuf[1], mbuf[2], mbuf[3]} = a;
    mcap = 0;
    case (o)
      op_sector_erase: {mbuf[0], mlen} = {8'h20, 32'd4};
      op_block32k_erase: {mbuf[0], mlen} = {8'h52, 32'd4};
      op_block64k_erase: {mbuf[0], mlen} = {8'hd8, 32'd4};
      op_byte_program: {mbuf[0], mbuf[4], mlen} = {8'h02, d, 32'd5};
      op_single: {mbuf[0], mlen} = {d, 32'd1};
      op_raw: mbuf[0] = d;
      default: {mbuf[0], mlen, mcap} = {8'h9f, 32'd4, 32'd1};
    endcase
    tick();
  endtask

  // run one transfer; far side holds off draining for hold cycles
  task automatic go(input string name, input int hold);
    int n, k;
    logic [7:0] e;
    got_q.delete();
    chk_byte(length_o, mlen[7:0]);
    start = 1'b1;
    tick();
    chk_flag(cs_n, 1'b0);
    chk_flag(busy, 1'b1);
    length = 8'h07;
    length_wr = 1'b1;
    tick();
    start = 1'b0;
    length_wr = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      if (hold > 0 && n == hold) begin
        chk_flag(busy, 1'b1);
        chk_flag(rsp_valid, 1'b1);
      end
      rsp_ready = (n >= hold) ? rnd() % 2 : 1'b0;
      if (rsp_ready && rsp_valid)
        got_q.push_back(rsp_data);
      tick();
      n++;
    end
    chk_flag(done, 1'b1);
    rsp_ready = 1'b1;
    for (k = 0; k < 20; k++) begin
      if (rsp_valid)
        got_q.push_back(rsp_data);
      tick();
    end
    rsp_ready = 1'b0;
    chk_flag(cs_n, 1'b1);
    chk_flag(sck, 1'b0);
    chk_byte(length_o, mlen[7:0]);
    chk_byte(8'(flash_model_inst.rx_q.size()), mlen[7:0]);
    for (k = 0; k < mlen; k++) begin
      e = (k < 8) ? mbuf[k] : 8'hff;
      chk_byte(flash_model_inst.rx_q[k], e);
    end
    chk_byte(8'(got_q.size()), mcap ? 8'(mlen - 1) : 8'h00);
    for (k = 0; k < got_q.size(); k++) begin
      e = reply[63 - 8 * (k % 8) -: 8];
      chk_byte(got_q[k], e);
      if (k < 8) begin
        rsp_index = 3'(k);
        tick();
        chk_byte(rsp_byte, e);
      end
    end
    $display("test %s done", name);
  endtask

  initial begin
    {nrst, load, cmd_wr, length_wr, start, rsp_ready} = '0;
    {addr, data, cmd_byte, length, cmd_index, rsp_index} = '0;
    op = op_raw;
    n_fail = 0;
    n_checks = 0;
    reply = {rnd(), rnd()};
    repeat (4) @(posedge clk);
    tick();
    nrst = 1'b1;
    tick();
    start = 1'b1;
    tick();
    start = 1'b0;
    tick();
    chk_flag(busy, 1'b0);
    chk_flag(cs_n, 1'b1);
    foreach (eops[i]) begin
      load_cmd(eops[i], rnd(), 8'h00);
      go("erase", 0);
    end
    load_cmd(op_byte_program, rnd(), rnd());
    go("program", 0);
    repeat (6) begin
      load_cmd(op_single, rnd(), rnd());
      go("single", 0);
    end
    reply = {ID_CODE, rnd(), 8'h00};
    load_cmd(op_read_id, 24'h000000, 8'h00);
    go("read id", 0);
    reply = {rnd(), rnd()};
    for (int k = 0; k < 8; k++) begin
      mbuf[k] = rnd();
      cmd_index = 3'(k);
      cmd_byte = mbuf[k];
      cmd_wr = 1'b1;
      tick();
    end
    cmd_wr = 1'b0;
    load_cmd(op_raw, rnd(), rnd());
    length = 8'h0a;
    length_wr = 1'b1;
    tick();
    length_wr = 1'b0;
    tick();
    {mlen, mcap} = {32'd10, 32'd1};
    go("raw stall", 800);
    test_done();
  end

  initial begin
    #2000000;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
